// ==== hdl/stwp_dev.sv ====
//
// Contract
// - Capture command bits on shift clock rise
// - Launch output bits on shift clock rise
// - Host samples output on falling edge
// - Host changes command line on falling edge
// - Host alone generates the shift clock
// - Output carries result, calibration or status
// - Five sequences: pressure, temperature, two calibration, reset
// - Three high start, three low stop bits
// - Four-bit setup field selects the reading
// - Acknowledge conversion low-to-high in last stop
// - Host gives two clocks, then holds low
// - Output falls when conversion completes, clock low
// - Seventeen clocks shift out 16-bit result
// - Paused readout keeps position and resumes
// - Host reads result before next conversion
// - Reset pattern recognised in any state
// - Host sends reset before first conversion
// - Host ignores output during reset pattern
// - Host supplies independent 32.768 kHz master clock
// - Four 16-bit calibration words are held
module stwp_dev
  import stwp_pkg::*;
#(
  parameter logic [3:0]  P_SETUP_PRESSURE    = SETUP_PRESSURE,
  parameter logic [3:0]  P_SETUP_TEMPERATURE = SETUP_TEMPERATURE,
  parameter logic [3:0]  P_SETUP_CAL13       = SETUP_CAL13,
  parameter logic [3:0]  P_SETUP_CAL24       = SETUP_CAL24,
  parameter logic [20:0] P_RESET_PATTERN     = RESET_PATTERN,
  parameter logic [63:0] P_CAL_DATA          = CAL_DATA_DEFAULT,
  parameter int          CONV_CYCLES         = CONV_MCLK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_pressure_result,
  input  wire logic [15:0] i_temperature_result,
  output logic             o_conv_busy,
  stwp_if.dev              bus
);

  // Counter below is 16 bits wide
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_chk_conv
    $error("CONV_CYCLES out of range");
  end

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_CMD  = 5'h02,
    D_ACK  = 5'h04,
    D_WAIT = 5'h08,
    D_READ = 5'h10
  } stwp_dst_t;

  // Calibration pair for the two readout commands
  function automatic logic [31:0] cal_pair(input logic second);
    logic [31:0] pair;
    pair = second ? {P_CAL_DATA[47:32], P_CAL_DATA[15:0]}
                  : {P_CAL_DATA[63:48], P_CAL_DATA[31:16]};
    return pair;
  endfunction

  stwp_dst_t   st_reg;
  stwp_dst_t   st_next;
  logic [20:0] hist_reg;
  logic [20:0] hist_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic        sdo_reg;
  logic        sdo_next;
  stwp_sel_t   sel_reg;
  stwp_sel_t   sel_next;
  logic        start_tgl_reg;
  logic        start_tgl_next;

  logic        conv_tgl_reg;
  logic        conv_tgl_next;
  logic [15:0] ccnt_reg;
  logic [15:0] ccnt_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic        mclk_prev_reg;
  logic        mclk_prev_next;
  logic        busy_reg;
  logic        busy_next;
  logic        mclk_s;
  logic        start_s;
  logic [20:0] nh;
  logic [3:0]  code;

  // Shift-clock domain: frame decode and output shifting
  always_comb begin
    st_next        = st_reg;
    cnt_next       = cnt_reg;
    sh_next        = sh_reg;
    sdo_next       = sdo_reg;
    sel_next       = sel_reg;
    start_tgl_next = start_tgl_reg;
    nh             = {hist_reg[19:0], bus.din};
    code           = nh[6:3];
    hist_next      = nh;
    case (st_reg)
      D_IDLE: begin
        if (nh[2:0] == START_FRAME) begin
          st_next  = D_CMD;
          cnt_next = FRAME_TAIL;
        end
      end
      D_CMD: begin
        cnt_next = cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          st_next = D_IDLE;
          if (nh[2:0] == STOP_FRAME) begin
            // Setup field picks the reading
            if (code == P_SETUP_PRESSURE || code == P_SETUP_TEMPERATURE) begin
              sel_next = (code == P_SETUP_PRESSURE) ? SEL_PRESSURE : SEL_TEMPERATURE;
              sdo_next = 1'b1;
              cnt_next = ACK_CLOCKS;
              st_next  = D_ACK;
            end else if (code == P_SETUP_CAL13 || code == P_SETUP_CAL24) begin
              sel_next = (code == P_SETUP_CAL13) ? SEL_CAL13 : SEL_CAL24;
              sh_next  = cal_pair(code == P_SETUP_CAL24);
              cnt_next = CAL_BITS;
              st_next  = D_READ;
            end
          end
        end
      end
      D_ACK: begin
        // Two clocks after the acknowledge, then conversion starts
        cnt_next = cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          start_tgl_next = ~start_tgl_reg;
          st_next        = D_WAIT;
        end
      end
      D_WAIT: begin
        // First of the readout clocks launches the top bit
        sdo_next = result_reg[15];
        sh_next  = {result_reg[14:0], 17'h00000};
        cnt_next = RESULT_REST;
        st_next  = D_READ;
      end
      D_READ: begin
        // State only moves on clock edges, so a pause holds position
        if (cnt_reg != 6'h00) begin
          sdo_next = sh_reg[31];
          sh_next  = {sh_reg[30:0], 1'b0};
          cnt_next = cnt_reg - 6'h01;
        end else begin
          sdo_next = 1'b0;
          st_next  = D_IDLE;
        end
      end
      default: begin
        st_next = D_IDLE;
      end
    endcase
    // Reset pattern overrides any state
    if (nh == P_RESET_PATTERN) begin
      st_next  = D_IDLE;
      sdo_next = 1'b0;
      cnt_next = 6'h00;
    end
  end

  // Shift-clock registers; clock stands still between frames
  always_ff @(posedge bus.sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg        <= D_IDLE;
      hist_reg      <= 21'h000000;
      cnt_reg       <= 6'h00;
      sh_reg        <= 32'h00000000;
      sdo_reg       <= 1'b0;
      sel_reg       <= SEL_PRESSURE;
      start_tgl_reg <= 1'b0;
    end else begin
      st_reg        <= st_next;
      hist_reg      <= hist_next;
      cnt_reg       <= cnt_next;
      sh_reg        <= sh_next;
      sdo_reg       <= sdo_next;
      sel_reg       <= sel_next;
      start_tgl_reg <= start_tgl_next;
    end
  end

  // Master clock and start event into the core clock
  stwp_sync u_sync_mclk (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (bus.mclk),
    .o_q     (mclk_s)
  );

  stwp_sync u_sync_start (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (start_tgl_reg),
    .o_q     (start_s)
  );

  // Conversion timer counts master clock rises while a start is pending
  always_comb begin
    mclk_prev_next = mclk_s;
    conv_tgl_next  = conv_tgl_reg;
    ccnt_next      = ccnt_reg;
    result_next    = result_reg;
    busy_next      = start_s ^ conv_tgl_reg;
    if (!busy_next) begin
      ccnt_next = 16'h0000;
    end else if (mclk_s && !mclk_prev_reg) begin
      if (ccnt_reg == 16'(CONV_CYCLES - 1)) begin
        // Selection word is stable while the shift clock is held
        result_next   = (sel_reg == SEL_TEMPERATURE) ? i_temperature_result : i_pressure_result;
        conv_tgl_next = start_s;
        ccnt_next     = 16'h0000;
      end else begin
        ccnt_next = ccnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mclk_prev_reg <= 1'b0;
      conv_tgl_reg  <= 1'b0;
      ccnt_reg      <= 16'h0000;
      result_reg    <= 16'h0000;
      busy_reg      <= 1'b0;
    end else begin
      mclk_prev_reg <= mclk_prev_next;
      conv_tgl_reg  <= conv_tgl_next;
      ccnt_reg      <= ccnt_next;
      result_reg    <= result_next;
      busy_reg      <= busy_next;
    end
  end

  assign o_conv_busy = busy_reg;

  // While waiting the line shows conversion status; only one toggle moves then
  assign bus.dout = (st_reg == D_WAIT) ? (start_tgl_reg ^ conv_tgl_reg) : sdo_reg;

endmodule

// ==== hdl/stwp_pkg.sv ====
package stwp_pkg;

  // Clock rates and conversion timing
  localparam int     CLK_PERIOD_NS    = 10;
  localparam longint CLK_FREQ_HZ      = 64'h3B9ACA00 / CLK_PERIOD_NS;
  localparam longint MCLK_FREQ_HZ     = 64'h8000;
  localparam longint CONV_TIME_US     = 64'h88B8;
  // Longest conversion time, rounded down to whole master clock periods
  localparam int     CONV_MCLK_CYCLES = int'(CONV_TIME_US * MCLK_FREQ_HZ / 64'hF4240);
  localparam int     MCLK_HALF_CYCLES = int'(CLK_FREQ_HZ / (64'h2 * MCLK_FREQ_HZ));
  localparam int     SCLK_HALF_CYCLES = 4;

  // Frame layout on the command line
  localparam logic [2:0] START_FRAME   = 3'h7;
  localparam logic [2:0] STOP_FRAME    = 3'h0;
  localparam logic [5:0] FRAME_CLOCKS  = 6'h0A;
  localparam logic [5:0] FRAME_TAIL    = 6'h07;
  localparam logic [5:0] ACK_CLOCKS    = 6'h02;
  localparam logic [5:0] RESULT_CLOCKS = 6'h11;
  localparam logic [5:0] RESULT_REST   = 6'h0F;
  localparam logic [5:0] CAL_CLOCKS    = 6'h21;
  localparam logic [5:0] CAL_BITS      = 6'h20;
  localparam logic [5:0] RESET_CLOCKS  = 6'h15;

  // Setup codes and reset pattern
  localparam logic [3:0]  SETUP_PRESSURE    = 4'h8;
  localparam logic [3:0]  SETUP_TEMPERATURE = 4'h9;
  localparam logic [3:0]  SETUP_CAL13       = 4'h5;
  localparam logic [3:0]  SETUP_CAL24       = 4'h6;
  localparam logic [20:0] RESET_PATTERN     = 21'h0AAAAA;

  // Calibration words one to four, top word first
  localparam logic [63:0] CAL_DATA_DEFAULT = 64'h1234_5678_9ABC_DEF0;

  typedef enum logic [2:0] {
    CMD_RESET       = 3'h0,
    CMD_PRESSURE    = 3'h1,
    CMD_TEMPERATURE = 3'h2,
    CMD_CAL13       = 3'h3,
    CMD_CAL24       = 3'h4
  } stwp_cmd_t;

  typedef enum logic [1:0] {
    SEL_PRESSURE    = 2'h0,
    SEL_TEMPERATURE = 2'h1,
    SEL_CAL13       = 2'h2,
    SEL_CAL24       = 2'h3
  } stwp_sel_t;

endpackage

// ==== hdl/stwp_if.sv ====
interface stwp_if;
  logic sclk;
  logic din;
  logic dout;
  logic mclk;

  // Sensor side
  modport dev (
    input  sclk,
    input  din,
    input  mclk,
    output dout
  );

  // Controller side
  modport host (
    output sclk,
    output din,
    output mclk,
    input  dout
  );
endinterface

// ==== hdl/stwp_sync.sv ====
module stwp_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_reg;
  logic q_reg;

  // Two stages; only the second is read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;

endmodule

// ==== hdl/stwp_host.sv ====
module stwp_host
  import stwp_pkg::*;
#(
  parameter logic [3:0]  P_SETUP_PRESSURE    = SETUP_PRESSURE,
  parameter logic [3:0]  P_SETUP_TEMPERATURE = SETUP_TEMPERATURE,
  parameter logic [3:0]  P_SETUP_CAL13       = SETUP_CAL13,
  parameter logic [3:0]  P_SETUP_CAL24       = SETUP_CAL24,
  parameter logic [20:0] P_RESET_PATTERN     = RESET_PATTERN,
  parameter int          SCLK_HALF           = SCLK_HALF_CYCLES,
  parameter int          MCLK_HALF           = MCLK_HALF_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cmd_valid,
  input  wire stwp_cmd_t   i_cmd,
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic [31:0]      o_data,
  stwp_if.host             bus
);

  // Sampling through the synchroniser needs a long enough half period
  if (SCLK_HALF < 4 || SCLK_HALF > 65535 || MCLK_HALF < 1 || MCLK_HALF > 65535) begin : g_chk_div
    $error("Clock divider out of range");
  end

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SEND = 5'h02,
    H_ACK  = 5'h04,
    H_WAIT = 5'h08,
    H_READ = 5'h10
  } stwp_hst_t;

  stwp_hst_t   st_reg, st_next;
  logic [15:0] div_reg, div_next;
  logic        sclk_reg, sclk_next;
  logic        din_reg, din_next;
  logic [20:0] tx_reg, tx_next;
  logic [5:0]  pul_reg, pul_next;
  logic [31:0] rx_reg, rx_next;
  logic        conv_reg, conv_next;
  logic        rst_reg, rst_next;
  logic        done_reg, done_next;
  logic [31:0] data_reg, data_next;
  logic        ready_reg, ready_next;
  logic [15:0] mdiv_reg, mdiv_next;
  logic        mclk_reg, mclk_next;
  logic        dout_s;
  logic        active;
  logic        tick;
  logic        fall;
  logic [3:0]  code;
  logic [20:0] frame;

  stwp_sync u_sync_dout (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     (bus.dout),
    .o_q     (dout_s)
  );

  // Shift clock divider, frame sequencing and sampling
  always_comb begin
    st_next    = st_reg;
    tx_next    = tx_reg;
    pul_next   = pul_reg;
    rx_next    = rx_reg;
    din_next   = din_reg;
    conv_next  = conv_reg;
    rst_next   = rst_reg;
    data_next  = data_reg;
    done_next  = 1'b0;
    ready_next = 1'b0;
    active     = (st_reg == H_SEND) || (st_reg == H_ACK) || (st_reg == H_READ);
    tick       = active && (div_reg == 16'(SCLK_HALF - 1));
    fall       = tick && sclk_reg;
    div_next   = (active && !tick) ? div_reg + 16'h0001 : 16'h0000;
    sclk_next  = active ? (sclk_reg ^ tick) : 1'b0;
    case (i_cmd)
      CMD_PRESSURE:    code = P_SETUP_PRESSURE;
      CMD_TEMPERATURE: code = P_SETUP_TEMPERATURE;
      CMD_CAL13:       code = P_SETUP_CAL13;
      default:         code = P_SETUP_CAL24;
    endcase
    frame = {START_FRAME, code, STOP_FRAME, 11'h000};
    case (st_reg)
      H_IDLE: begin
        ready_next = !i_cmd_valid;
        if (i_cmd_valid) begin
          rst_next  = (i_cmd == CMD_RESET);
          conv_next = (i_cmd == CMD_PRESSURE) || (i_cmd == CMD_TEMPERATURE);
          if (i_cmd == CMD_RESET) begin
            din_next = P_RESET_PATTERN[20];
            tx_next  = {P_RESET_PATTERN[19:0], 1'b0};
            pul_next = RESET_CLOCKS;
          end else begin
            din_next = frame[20];
            tx_next  = {frame[19:0], 1'b0};
            pul_next = FRAME_CLOCKS;
          end
          st_next = H_SEND;
        end
      end
      H_SEND: begin
        // Output line is not looked at here
        if (fall) begin
          din_next = tx_reg[20];
          tx_next  = {tx_reg[19:0], 1'b0};
          pul_next = pul_reg - 6'h01;
          if (pul_reg == 6'h01) begin
            din_next = 1'b0;
            rx_next  = 32'h00000000;
            if (rst_reg) begin
              done_next = 1'b1;
              st_next   = H_IDLE;
            end else if (conv_reg) begin
              pul_next = ACK_CLOCKS;
              st_next  = H_ACK;
            end else begin
              pul_next = CAL_CLOCKS;
              st_next  = H_READ;
            end
          end
        end
      end
      H_ACK: begin
        if (fall) begin
          pul_next = pul_reg - 6'h01;
          if (pul_reg == 6'h01) begin
            st_next = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        // Falling output marks end of conversion
        if (!dout_s) begin
          pul_next = RESULT_CLOCKS;
          st_next  = H_READ;
        end
      end
      H_READ: begin
        if (fall) begin
          pul_next = pul_reg - 6'h01;
          if (pul_reg != 6'h01) begin
            rx_next = {rx_reg[30:0], dout_s};
          end else begin
            // Whole word taken before a new command is accepted
            data_next = rx_reg;
            done_next = 1'b1;
            st_next   = H_IDLE;
          end
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
    // Free-running master clock, unrelated to the shift clock
    mdiv_next = (mdiv_reg == 16'(MCLK_HALF - 1)) ? 16'h0000 : mdiv_reg + 16'h0001;
    mclk_next = mclk_reg ^ (mdiv_reg == 16'(MCLK_HALF - 1));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg    <= H_IDLE;
      div_reg   <= 16'h0000;
      sclk_reg  <= 1'b0;
      din_reg   <= 1'b0;
      tx_reg    <= 21'h000000;
      pul_reg   <= 6'h00;
      rx_reg    <= 32'h00000000;
      conv_reg  <= 1'b0;
      rst_reg   <= 1'b0;
      done_reg  <= 1'b0;
      data_reg  <= 32'h00000000;
      ready_reg <= 1'b0;
      mdiv_reg  <= 16'h0000;
      mclk_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      div_reg   <= div_next;
      sclk_reg  <= sclk_next;
      din_reg   <= din_next;
      tx_reg    <= tx_next;
      pul_reg   <= pul_next;
      rx_reg    <= rx_next;
      conv_reg  <= conv_next;
      rst_reg   <= rst_next;
      done_reg  <= done_next;
      data_reg  <= data_next;
      ready_reg <= ready_next;
      mdiv_reg  <= mdiv_next;
      mclk_reg  <= mclk_next;
    end
  end

  assign o_cmd_ready = ready_reg;
  assign o_done      = done_reg;
  assign o_data      = data_reg;
  assign bus.sclk    = sclk_reg;
  assign bus.din     = din_reg;
  assign bus.mclk    = mclk_reg;

endmodule

// ==== test/stwp_monitor.sv ====
module stwp_monitor
  import stwp_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYCLES,
  parameter int MCLK_HALF = MCLK_HALF_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_sclk,
  input  wire logic i_din,
  input  wire logic i_dout,
  input  wire logic i_mclk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [19:0] hist_reg;
  logic [19:0] hist_next;
  logic [9:0]  frame;
  logic [7:0]  hi_reg;
  logic [7:0]  hi_next;
  logic [11:0] mcnt_reg;
  logic [11:0] mcnt_next;
  logic        mclk_reg;
  logic        seen_reg;
  logic        seen_next;

  // Frame as it stands once the bit on this rise is captured
  assign frame = {hist_reg[8:0], i_din};

  // Command line history in the shift clock domain
  always_comb hist_next = {hist_reg[18:0], i_din};

  always_ff @(posedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) hist_reg <= '0;
    else hist_reg <= hist_next;
  end

  // Phase counters; first master clock phase after reset is skipped
  always_comb begin
    hi_next   = i_sclk ? hi_reg + 8'h01 : 8'h00;
    mcnt_next = (i_mclk != mclk_reg) ? 12'h001 : mcnt_reg + 12'h001;
    seen_next = seen_reg | (i_mclk != mclk_reg);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_reg   <= 8'h00;
      mcnt_reg <= 12'h000;
      mclk_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      hi_reg   <= hi_next;
      mcnt_reg <= mcnt_next;
      mclk_reg <= i_mclk;
      seen_reg <= seen_next;
    end
  end

  din_low_change_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $changed(i_din) |-> !i_sclk)
    else $error("Command line moved while shift clock high");
  dout_launch_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $changed(i_dout) && i_sclk |-> $rose(i_sclk))
    else $error("Data out moved away from a shift clock rise");
  dout_rise_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $rose(i_dout) |-> $rose(i_sclk))
    else $error("Data out rose without a shift clock rise");
  dout_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $changed(i_dout) && !i_sclk |-> $fell(i_dout))
    else $error("Data out moved while shift clock held low");
  sclk_high_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $fell(i_sclk) |-> hi_reg == 8'(SCLK_HALF))
    else $error("Shift clock high phase has wrong length");
  mclk_phase_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) $changed(i_mclk) && seen_reg |-> mcnt_reg == 12'(MCLK_HALF))
    else $error("Master clock phase has wrong length");
  conv_ack_a: assert property (
    @(posedge i_sclk) disable iff (!i_rst_b)
    frame == {START_FRAME, SETUP_PRESSURE, STOP_FRAME} || frame == {START_FRAME, SETUP_TEMPERATURE, STOP_FRAME}
    |=> i_dout)
    else $error("No acknowledge on last stop bit");
  conv_done_a: assert property (
    @(posedge i_sclk) disable iff (!i_rst_b)
    frame == {START_FRAME, SETUP_PRESSURE, STOP_FRAME} || frame == {START_FRAME, SETUP_TEMPERATURE, STOP_FRAME}
    |=> ##1 i_dout ##1 !i_dout)
    else $error("Completion not signalled before readout");
  cal_quiet_a: assert property (
    @(posedge i_sclk) disable iff (!i_rst_b)
    frame == {START_FRAME, SETUP_CAL13, STOP_FRAME} || frame == {START_FRAME, SETUP_CAL24, STOP_FRAME} |=> !i_dout)
    else $error("Calibration frame gave an acknowledge");
  reset_idle_a: assert property (
    @(posedge i_sclk) disable iff (!i_rst_b) {hist_reg, i_din} == RESET_PATTERN |=> !i_dout)
    else $error("Data out not low after reset pattern");
endmodule

// ==== test/testbench.sv ====
module testbench
  import stwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Short master clock and conversion keep the run small
  localparam int MCLK_H = 3;
  localparam int CONV_N = 4;

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL at %0t: got %h expected %h", $time, got, exp); end end

  logic        i_clk;
  logic        i_rst_b;
  logic        cmd_valid;
  stwp_cmd_t   cmd;
  logic        cmd_ready;
  logic        done;
  logic [31:0] data;
  logic        conv_busy;
  logic [15:0] press_val;
  logic [15:0] temp_val;
  int          fails;
  int          samples_checked;

  stwp_if link();

  stwp_host #(.MCLK_HALF(MCLK_H)) stwp_host_inst (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_cmd_valid(cmd_valid),
    .i_cmd      (cmd),
    .o_cmd_ready(cmd_ready),
    .o_done     (done),
    .o_data     (data),
    .bus        (link.host)
  );

  stwp_dev #(.CONV_CYCLES(CONV_N)) stwp_dev_inst (
    .i_clk               (i_clk),
    .i_rst_b             (i_rst_b),
    .i_pressure_result   (press_val),
    .i_temperature_result(temp_val),
    .o_conv_busy         (conv_busy),
    .bus                 (link.dev)
  );

  stwp_monitor #(.SCLK_HALF(SCLK_HALF_CYCLES), .MCLK_HALF(MCLK_H)) stwp_monitor_inst (
    .i_clk  (i_clk),
    .i_rst_b(i_rst_b),
    .i_sclk (link.sclk),
    .i_din  (link.din),
    .i_dout (link.dout),
    .i_mclk (link.mclk)
  );

  // Core clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One command through the user port; valid drops at the edge that takes it
  task automatic run_cmd(input stwp_cmd_t c, output logic [31:0] d, output logic busy_seen);
    int n;
    busy_seen = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(cmd_ready, 1'b1)
    @(posedge i_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge i_clk);
      if (conv_busy === 1'b1) busy_seen = 1'b1;
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(cmd_ready, 1'b0)
    d = data;
  endtask

  // Reset before anything else; result register must not move
  task automatic t_reset_first;
    logic [31:0] d;
    logic        b;
    run_cmd(CMD_RESET, d, b);
    `CHK(d, 32'h0000_0000)
    `CHK(b, 1'b0)
  endtask

  // Both calibration pairs, and an unknown code that falls back to the second pair
  task automatic t_cal_words;
    logic [31:0] d;
    logic        b;
    run_cmd(CMD_CAL13, d, b);
    `CHK(d, {CAL_DATA_DEFAULT[63:48], CAL_DATA_DEFAULT[31:16]})
    `CHK(b, 1'b0)
    run_cmd(CMD_CAL24, d, b);
    `CHK(d, {CAL_DATA_DEFAULT[47:32], CAL_DATA_DEFAULT[15:0]})
    run_cmd(stwp_cmd_t'(3'h5), d, b);
    `CHK(d, {CAL_DATA_DEFAULT[47:32], CAL_DATA_DEFAULT[15:0]})
  endtask

  // Pressure read with distinct values on both sources, so a wrong pick shows
  task automatic t_pressure;
    logic [31:0] d;
    logic        b;
    @(posedge i_clk);
    press_val <= 16'hA5C3;
    temp_val <= 16'h3C5A;
    run_cmd(CMD_PRESSURE, d, b);
    `CHK(d, 32'h0000_A5C3)
    `CHK(b, 1'b1)
    `CHK(conv_busy, 1'b0)
  endtask

  // Temperature read with both end bits set to catch a shift slip
  task automatic t_temperature;
    logic [31:0] d;
    logic        b;
    @(posedge i_clk);
    press_val <= 16'h7FFE;
    temp_val <= 16'h8001;
    run_cmd(CMD_TEMPERATURE, d, b);
    `CHK(d, 32'h0000_8001)
    `CHK(b, 1'b1)
  endtask

  // Conversion, then reset, then a calibration read straight after
  task automatic t_conv_reset_cal;
    logic [31:0] d;
    logic        b;
    @(posedge i_clk);
    press_val <= 16'h0001;
    run_cmd(CMD_PRESSURE, d, b);
    `CHK(d, 32'h0000_0001)
    run_cmd(CMD_RESET, d, b);
    `CHK(d, 32'h0000_0001)
    run_cmd(CMD_CAL13, d, b);
    `CHK(d, {CAL_DATA_DEFAULT[63:48], CAL_DATA_DEFAULT[31:16]})
  endtask

  // Main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = CMD_RESET;
    press_val = 16'h0000;
    temp_val = 16'h0000;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset_first();
    t_cal_words();
    t_pressure();
    t_temperature();
    t_conv_reset_cal();
    stop_test();
  end

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    stop_test();
  end
endmodule
